/* File: bsc_pkg.sv */
// package for the baseline stabilizer and dual-gain combiner
// assumes one 25 MHz apb clock that also carries the sample stream
package bsc_pkg;

    // ****************************************************
    // register map (byte addresses)
    // ****************************************************
    localparam logic [7:0] BSC_CTRL_OFS     = 8'h00;
    localparam logic [7:0] BSC_TARGET0_OFS  = 8'h04;
    localparam logic [7:0] BSC_TARGET1_OFS  = 8'h08;
    localparam logic [7:0] BSC_GAIN_OFS     = 8'h0c;
    localparam logic [7:0] BSC_CBASE_OFS    = 8'h10;
    localparam logic [7:0] BSC_EST0_OFS     = 8'h14;
    localparam logic [7:0] BSC_EST1_OFS     = 8'h18;
    localparam logic [7:0] BSC_LOWCNT_OFS   = 8'h1c;

    // ****************************************************
    // fields and reset values
    // ****************************************************
    localparam int         BSC_CTRL_STAB0_BIT = 0;
    localparam int         BSC_CTRL_STAB1_BIT = 1;
    localparam int         BSC_CTRL_COMB_BIT  = 2;
    localparam logic [2:0] BSC_CTRL_RST       = 3'h0;
    localparam logic [15:0] BSC_TARGET_RST    = 16'h0000;
    localparam logic [5:0] BSC_GAIN_RST       = 6'h08;
    localparam logic [5:0] BSC_GAIN_MIN       = 6'h01;
    localparam logic [5:0] BSC_GAIN_MAX       = 6'h20;
    localparam logic [15:0] BSC_CBASE_RST     = 16'h0000;

    // ****************************************************
    // sample codes and tracker tuning
    // ****************************************************
    localparam int          BSC_SW          = 16;
    localparam logic [15:0] BSC_CODE_MIN    = 16'h8000;
    localparam logic [15:0] BSC_CODE_MAX    = 16'h7fff;
    localparam int          BSC_TRACK_SHIFT = 12;
    localparam int          BSC_BL_WINDOW   = 64;
    localparam int          BSC_CORES       = 2;

    // one sample from each branch, or the two output channels
    typedef struct packed {
        logic signed [15:0] ch1;
        logic signed [15:0] ch0;
    } bsc_pair_s;

endpackage : bsc_pkg

/* File: bsc_skid.sv */
// two-entry skid buffer carrying sample pairs to the record path
// assumes both sides use valid/ready on the same clock
`timescale 1ns/1ps
module bsc_skid #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic         main_v_reg;
    logic         main_v_next;
    logic [W-1:0] main_d_reg;
    logic [W-1:0] main_d_next;
    logic         spare_v_reg;
    logic         spare_v_next;
    logic [W-1:0] spare_d_reg;
    logic [W-1:0] spare_d_next;
    logic         rdy_reg;
    logic         rdy_next;

    // ****************************************************
    // next state: spare catches the word that arrives during a stall
    // ****************************************************
    always_comb
    begin
        main_v_next  = main_v_reg;
        main_d_next  = main_d_reg;
        spare_v_next = spare_v_reg;
        spare_d_next = spare_d_reg;
        if (out_ready || !main_v_reg)
        begin
            // main empties this cycle: refill from spare first to keep order
            // ready was low, so the word at the input is not ours to take
            if (spare_v_reg)
            begin
                main_v_next  = 1'b1;
                main_d_next  = spare_d_reg;
                spare_v_next = 1'b0;
            end
            else
            begin
                main_v_next = in_valid;
                main_d_next = in_data;
            end
        end
        else if (in_valid && !spare_v_reg)
        begin
            spare_v_next = 1'b1;
            spare_d_next = in_data;
        end
        rdy_next = !spare_v_next;
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_v_reg  <= 1'b0;
            main_d_reg  <= '0;
            spare_v_reg <= 1'b0;
            spare_d_reg <= '0;
            rdy_reg     <= 1'b1;
        end
        else
        begin
            rdy_reg     <= rdy_next;
            main_v_reg  <= main_v_next;
            main_d_reg  <= main_d_next;
            spare_v_reg <= spare_v_next;
            spare_d_reg <= spare_d_next;
        end
    end

    // ready is a flop: full only when the spare holds a word
    assign in_ready  = rdy_reg;
    assign out_valid = main_v_reg;
    assign out_data  = main_d_reg;

endmodule : bsc_skid

/* File: bsc_top.sv */
// baseline stabilizer per channel followed by a dual-gain combiner
// assumes samples are synchronous to pclk; ch0 is high gain, ch1 low gain
`timescale 1ns/1ps
module bsc_top
    import bsc_pkg::*;
#(
    parameter int TRACK_SHIFT = bsc_pkg::BSC_TRACK_SHIFT,
    parameter int BL_WINDOW   = bsc_pkg::BSC_BL_WINDOW,
    parameter bit INTERLEAVED = 1'b1
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // sample pairs from the converters
    input  wire logic              s_valid,
    output logic                   s_ready,
    input  wire bsc_pkg::bsc_pair_s s_data,
    // output channels to the record path
    output logic                   m_valid,
    input  wire logic              m_ready,
    output bsc_pkg::bsc_pair_s     m_data
);
    import bsc_pkg::*;

    localparam int AW = BSC_SW + TRACK_SHIFT + 2;

    // ****************************************************
    // helpers
    // ****************************************************
    // clip a wide signed value into the 16-bit code range
    function automatic logic signed [15:0] sat16(input logic signed [AW-1:0] v);
        if (v > $signed({{(AW-16){1'b0}}, BSC_CODE_MAX}))
            return BSC_CODE_MAX;
        else if (v < $signed({{(AW-16){1'b1}}, BSC_CODE_MIN}))
            return BSC_CODE_MIN;
        else
            return v[15:0];
    endfunction : sat16

    // widen a 16-bit code to tracker width
    function automatic logic signed [AW-1:0] wide(input logic signed [15:0] v);
        return {{(AW-16){v[15]}}, v};
    endfunction : wide

    // a gain write outside 1..32 is pulled to the nearest legal ratio
    function automatic logic [5:0] clamp_gain(input logic [31:0] v);
        if (v < 32'(BSC_GAIN_MIN))
            return BSC_GAIN_MIN;
        else if (v > 32'(BSC_GAIN_MAX))
            return BSC_GAIN_MAX;
        else
            return v[5:0];
    endfunction : clamp_gain

    // ****************************************************
    // registers
    // ****************************************************
    logic [2:0]          ctrl_reg;
    logic [2:0]          ctrl_next;
    logic signed [15:0]  target_reg [2];
    logic signed [15:0]  target_next [2];
    logic [5:0]          gain_reg;
    logic [5:0]          gain_next;
    logic signed [15:0]  cbase_reg;
    logic signed [15:0]  cbase_next;
    logic [31:0]         lowcnt_reg;
    logic [31:0]         lowcnt_next;
    logic                pready_reg;
    logic                pready_next;
    logic [31:0]         prdata_reg;
    logic [31:0]         prdata_next;
    logic                pslverr_reg;
    logic                pslverr_next;
    logic signed [AW-1:0] acc_reg [2][BSC_CORES];
    logic signed [AW-1:0] acc_next [2][BSC_CORES];
    logic                core_reg;
    logic                core_next;

    // datapath nets
    logic                accept;
    logic                bl_ready;
    logic                wr_hit;
    logic                hg_over;
    logic signed [15:0]  est [2][BSC_CORES];
    logic signed [15:0]  corr [2];
    logic signed [15:0]  comb;
    logic signed [AW-1:0] dev;
    logic signed [AW-1:0] err;
    logic signed [AW-1:0] raw_in [2];
    bsc_pair_s           out_pair;

    assign accept = s_valid && bl_ready;
    assign wr_hit = psel && penable && pready_reg && pwrite;
    assign raw_in[0] = wide(s_data.ch0);
    assign raw_in[1] = wide(s_data.ch1);

    // ****************************************************
    // apb slave: one wait-free access, answer registered in setup
    // ****************************************************
    always_comb
    begin
        ctrl_next      = ctrl_reg;
        target_next[0] = target_reg[0];
        target_next[1] = target_reg[1];
        gain_next      = gain_reg;
        cbase_next     = cbase_reg;
        pready_next    = psel && !penable;
        prdata_next    = 32'h0000_0000;
        pslverr_next   = 1'b0;
        // read data and error are fixed in the setup cycle
        if (psel && !penable)
        begin
            case (paddr)
                BSC_CTRL_OFS:    prdata_next = {29'h0, ctrl_reg};
                BSC_TARGET0_OFS: prdata_next = {16'h0, target_reg[0]};
                BSC_TARGET1_OFS: prdata_next = {16'h0, target_reg[1]};
                BSC_GAIN_OFS:    prdata_next = {26'h0, gain_reg};
                BSC_CBASE_OFS:   prdata_next = {16'h0, cbase_reg};
                BSC_EST0_OFS:    prdata_next = {est[0][1], est[0][0]};
                BSC_EST1_OFS:    prdata_next = {est[1][1], est[1][0]};
                BSC_LOWCNT_OFS:  prdata_next = lowcnt_reg;
                default:         pslverr_next = 1'b1;
            endcase
            // a write answers with zero read data
            if (pwrite)
            begin
                prdata_next = 32'h0000_0000;
            end
        end
        // writes land on the access edge only
        if (wr_hit)
        begin
            case (paddr)
                BSC_CTRL_OFS:    ctrl_next = pwdata[2:0];
                BSC_TARGET0_OFS: target_next[0] = pwdata[15:0];
                BSC_TARGET1_OFS: target_next[1] = pwdata[15:0];
                BSC_GAIN_OFS:    gain_next = clamp_gain(pwdata);
                BSC_CBASE_OFS:   cbase_next = pwdata[15:0];
                default:         ctrl_next = ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg      <= BSC_CTRL_RST;
            target_reg[0] <= BSC_TARGET_RST;
            target_reg[1] <= BSC_TARGET_RST;
            gain_reg      <= BSC_GAIN_RST;
            cbase_reg     <= BSC_CBASE_RST;
            pready_reg    <= 1'b0;
            prdata_reg    <= 32'h0000_0000;
            pslverr_reg   <= 1'b0;
        end
        else
        begin
            ctrl_reg      <= ctrl_next;
            target_reg[0] <= target_next[0];
            target_reg[1] <= target_next[1];
            gain_reg      <= gain_next;
            cbase_reg     <= cbase_next;
            pready_reg    <= pready_next;
            prdata_reg    <= prdata_next;
            pslverr_reg   <= pslverr_next;
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // ****************************************************
    // baseline stabilizer
    // ****************************************************
    // estimates are the integer part of each tracker
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            for (int k = 0; k < BSC_CORES; k++)
            begin
                est[c][k] = sat16(acc_reg[c][k] >>> TRACK_SHIFT);
            end
        end
    end

    // correction and slow tracking; a pulse never enters the estimate
    always_comb
    begin
        core_next = core_reg;
        err       = '0;
        for (int c = 0; c < 2; c++)
        begin
            corr[c] = raw_in[c][15:0];
            for (int k = 0; k < BSC_CORES; k++)
            begin
                acc_next[c][k] = acc_reg[c][k];
            end
        end
        if (accept && INTERLEAVED)
        begin
            core_next = !core_reg; // even and odd samples from separate cores
        end
        for (int c = 0; c < 2; c++)
        begin
            if (ctrl_reg[c])
            begin
                // subtract the core's offset so the baseline sits on target
                corr[c] = sat16(raw_in[c] - wide(est[c][core_reg]));
                // deviation from target after the current correction
                err = raw_in[c] - wide(target_reg[c]) - wide(est[c][core_reg]);
                // only samples near the expected baseline feed the tracker
                if (accept && err < AW'(BL_WINDOW) && err > -AW'(BL_WINDOW))
                begin
                    acc_next[c][core_reg] = acc_reg[c][core_reg] + err;
                end
            end
        end
    end

    // trackers start at zero; a disabled channel keeps its estimate frozen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reg <= 1'b0;
            for (int c = 0; c < 2; c++)
            begin
                for (int k = 0; k < BSC_CORES; k++)
                begin
                    acc_reg[c][k] <= '0;
                end
            end
        end
        else
        begin
            core_reg <= core_next;
            acc_reg  <= acc_next;
        end
    end

    // ****************************************************
    // channel combiner
    // ****************************************************
    // overrange is judged on the raw high-gain code, before correction
    assign hg_over = (s_data.ch0 == BSC_CODE_MIN) || (s_data.ch0 == BSC_CODE_MAX);

    // truncating division toward zero keeps the baseline exact
    always_comb
    begin
        dev  = wide(corr[0]) - wide(cbase_reg);
        comb = sat16(wide(cbase_reg) + dev / $signed({{(AW-6){1'b0}}, gain_reg}));
        out_pair.ch0 = corr[0];
        out_pair.ch1 = corr[1];
        lowcnt_next  = lowcnt_reg;
        if (ctrl_reg[BSC_CTRL_COMB_BIT])
        begin
            if (hg_over)
            begin
                out_pair.ch1 = corr[1];
                if (accept)
                begin
                    lowcnt_next = lowcnt_reg + 32'h0000_0001;
                end
            end
            else
            begin
                out_pair.ch1 = comb;
            end
        end
    end

    // count of samples that fell back to low gain, wraps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lowcnt_reg <= 32'h0000_0000;
        end
        else
        begin
            lowcnt_reg <= lowcnt_next;
        end
    end

    // ****************************************************
    // output buffer: a stalled record path back-pressures the converters
    // ****************************************************
    bsc_skid #(
        .W ($bits(bsc_pair_s))
    ) u_skid (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (s_valid),
        .in_ready  (bl_ready),
        .in_data   (out_pair),
        .out_valid (m_valid),
        .out_ready (m_ready),
        .out_data  (m_data)
    );

    assign s_ready = bl_ready;

endmodule : bsc_top

/* File: bsc_top_sva.sv */
// port-level checks for the stabilizer and combiner top
// assumes it is bound to bsc_top and sees only its ports
`timescale 1ns/1ps
module bsc_top_sva
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // streams
    input wire logic              s_valid,
    input wire logic              s_ready,
    input wire bsc_pkg::bsc_pair_s s_data,
    input wire logic              m_valid,
    input wire logic              m_ready,
    input wire bsc_pkg::bsc_pair_s m_data
);
    // ********
    // control mirror
    // ********
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic       hg_ovr;

    // mirror of the enables, so data checks know which path is active
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (psel && penable && pready && pwrite && paddr == BSC_CTRL_OFS)
            ctrl_next = pwdata[2:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= BSC_CTRL_RST;
        else
            ctrl_reg <= ctrl_next;
    end
    assign hg_ovr = (s_data.ch0 == BSC_CODE_MIN) || (s_data.ch0 == BSC_CODE_MAX);

    // ********
    // assertions
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_take_empty;
        s_valid && s_ready && !m_valid;
    endsequence

    a_apb_no_wait: assert property (s_setup |=> pready)
        else $error("apb answer missing after setup");
    a_pready_once: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_unmapped: assert property (pready && paddr > BSC_LOWCNT_OFS |-> pslverr)
        else $error("unmapped access without error");
    a_wr_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    a_out_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
        else $error("output word changed while stalled");
    a_in_to_out: assert property (s_valid && s_ready |=> m_valid)
        else $error("accepted pair not presented");
    a_full_refuse: assert property ($fell(s_ready) |-> $past(m_valid && !m_ready))
        else $error("input refused without a stall");
    a_pass_off: assert property ((ctrl_reg == 3'h0) and s_take_empty |=> m_data == $past(s_data))
        else $error("disabled path altered data");
    a_hg_chan0: assert property ((!ctrl_reg[0]) and s_take_empty |=> m_data.ch0 == $past(s_data.ch0))
        else $error("channel 0 not high gain");
    a_ovr_lowgain: assert property ((ctrl_reg[2] && !ctrl_reg[1] && hg_ovr) and s_take_empty
                                    |=> m_data.ch1 == $past(s_data.ch1))
        else $error("overrange did not select low gain");
endmodule : bsc_top_sva

bind bsc_top bsc_top_sva u_bsc_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
    .m_data(m_data));

/* File: bsc_conv_model.sv */
// converter pair source and record path sink for the combiner
// assumes the bench fills tx_q and reads rx_q by hierarchy
`timescale 1ns/1ps
module bsc_conv_model
    import bsc_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // record path holds off while high
    input  wire logic              stall,
    // converter side
    output logic                   s_valid,
    input  wire logic              s_ready,
    output bsc_pkg::bsc_pair_s     s_data,
    // record side
    input  wire logic              m_valid,
    output logic                   m_ready,
    input  wire bsc_pkg::bsc_pair_s m_data
);
    bsc_pair_s tx_q[$];
    bsc_pair_s rx_q[$];

    // source: a pair stands until taken; idle data is inverted so nothing stale looks valid
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_valid <= 1'b0;
            s_data  <= '1;
        end
        else if (!s_valid || s_ready)
        begin
            if (tx_q.size() > 0)
            begin
                s_valid <= 1'b1;
                s_data  <= tx_q.pop_front();
            end
            else
            begin
                s_valid <= 1'b0;
                s_data  <= ~s_data;
            end
        end
    end

    // sink: takes a word at each handshake, ready follows the stall request
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            m_ready <= 1'b0;
        else
        begin
            if (m_valid && m_ready)
                rx_q.push_back(m_data);
            m_ready <= !stall;
        end
    end
endmodule : bsc_conv_model

/* File: tb.sv */
// self-checking bench for the stabilizer and combiner top
// assumes the converter model feeds and drains the sample streams
`timescale 1ns/1ps
module tb;
    import bsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic s_valid, s_ready, m_valid, m_ready, stall;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    bsc_pair_s   s_data, m_data;
    logic [32:0] exp_q[$];
    int          err_count, n_tests, cycles;

    bsc_top #(.TRACK_SHIFT(2)) u_bsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
        .m_data(m_data));
    bsc_conv_model u_bsc_conv_model (.pclk(pclk), .presetn(presetn), .stall(stall), .s_valid(s_valid),
        .s_ready(s_ready), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));

    // ********
    // helpers
    // ********
    always #20 pclk = ~pclk;

    task automatic summarize();
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // a hang ends the run as a failure
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        check(rd, exp);
        check({31'h0, er}, {31'h0, eexp});
    endtask : rdchk

    // queue one pair and what the record path should see for it
    task automatic xfer(input logic [15:0] c1, c0, e1, e0, input logic care);
        u_bsc_conv_model.tx_q.push_back({c1, c0});
        exp_q.push_back({care, e1, e0});
    endtask : xfer

    task automatic settle();
        logic [32:0] e;
        while (u_bsc_conv_model.rx_q.size() < exp_q.size())
            @(posedge pclk);
        while (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e[32])
                check(u_bsc_conv_model.rx_q.pop_front(), e[31:0]);
            else
                void'(u_bsc_conv_model.rx_q.pop_front());
        end
    endtask : settle

    // ********
    // main sequence
    // ********
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; stall = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(BSC_CTRL_OFS, 32'h0, 1'b0);
        rdchk(BSC_GAIN_OFS, 32'h8, 1'b0);
        rdchk(BSC_CBASE_OFS, 32'h0, 1'b0);
        rdchk(8'h20, 32'h0, 1'b1);
        wr(BSC_EST0_OFS, 32'h1234);
        rdchk(BSC_EST0_OFS, 32'h0, 1'b0);
        wr(BSC_GAIN_OFS, 32'h0);
        rdchk(BSC_GAIN_OFS, 32'h1, 1'b0);
        wr(BSC_GAIN_OFS, 32'h28);
        rdchk(BSC_GAIN_OFS, 32'h20, 1'b0);
        // stalled record path: buffer fills, refuses, then drains in order
        stall <= 1'b1;
        xfer(16'h0064, 16'h8000, 16'h0064, 16'h8000, 1);
        xfer(16'h0001, 16'h7fff, 16'h0001, 16'h7fff, 1);
        xfer(16'h0002, 16'h0003, 16'h0002, 16'h0003, 1);
        xfer(16'hfffe, 16'hfffd, 16'hfffe, 16'hfffd, 1);
        repeat (8) @(posedge pclk);
        check({31'h0, s_ready}, 32'h0);
        stall <= 1'b0;
        settle();
        // combiner at gain 8 around code 0, then at gains 8, 32 and 1 around a positive base
        wr(BSC_GAIN_OFS, 32'h8);
        wr(BSC_CTRL_OFS, 32'h4);
        xfer(16'h0005, 16'h0320, 16'h0064, 16'h0320, 1);
        xfer(16'h0005, 16'hfcdf, 16'hff9c, 16'hfcdf, 1);
        xfer(16'h04d2, 16'h7fff, 16'h04d2, 16'h7fff, 1);
        xfer(16'hfc19, 16'h8000, 16'hfc19, 16'h8000, 1);
        settle();
        rdchk(BSC_LOWCNT_OFS, 32'h2, 1'b0);
        wr(BSC_CBASE_OFS, 32'h6666);
        rdchk(BSC_CBASE_OFS, 32'h6666, 1'b0);
        xfer(16'h0005, 16'h66b6, 16'h6670, 16'h66b6, 1);
        xfer(16'h0005, 16'h6649, 16'h6663, 16'h6649, 1);
        settle();
        wr(BSC_GAIN_OFS, 32'h20);
        xfer(16'h0005, 16'h66a6, 16'h6668, 16'h66a6, 1);
        settle();
        wr(BSC_GAIN_OFS, 32'h1);
        xfer(16'h0005, 16'h012c, 16'h012c, 16'h012c, 1);
        settle();
        // stabilizer on ch0 only, target programmed while disabled
        wr(BSC_CTRL_OFS, 32'h0);
        wr(BSC_TARGET0_OFS, 32'h999a);
        rdchk(BSC_TARGET0_OFS, 32'h999a, 1'b0);
        wr(BSC_CTRL_OFS, 32'h1);
        for (int i = 0; i < 40; i++)
        begin
            xfer(16'h0007, 16'h99ae, 16'h0007, (i == 0) ? 16'h99ae : 16'h999a, i == 0 || i > 35);
            xfer(16'h0007, 16'h99b8, 16'h0007, (i == 0) ? 16'h99b8 : 16'h999a, i == 0 || i > 35);
        end
        settle();
        rdchk(BSC_EST0_OFS, 32'h001e0014, 1'b0);
        rdchk(BSC_EST1_OFS, 32'h0, 1'b0);
        // a pulse sample is corrected but leaves the estimate alone
        xfer(16'h0007, 16'h0000, 16'h0007, 16'hffec, 1);
        xfer(16'h0007, 16'h99b8, 16'h0007, 16'h999a, 1);
        xfer(16'h0007, 16'h99ae, 16'h0007, 16'h999a, 1);
        xfer(16'h0007, 16'h99b8, 16'h0007, 16'h999a, 1);
        settle();
        summarize();
    end
endmodule : tb
